// [core/hude_consts.vh]
// Notes on behaviour
// R1: Host storage byte at 07H, core reads F7H.
// R2: Storage byte writes never interrupt the core.
// R3: Divisor select maps offset 00H to low byte.
// R4: Divisor select maps offset 01H to high byte.
// R5: Any host divisor write interrupts the core.
// R6: Master control bits 3-5 configure DMA.
// R7: Bit 5 drives host tx ready low.
// R8: Bit 5 drives core request from tx shadow.
// R9: Bit 4 drives host rx ready low.
// R10: Bit 4 drives core request from rx shadow.
// R11: Single mode: rx request while data present.
// R12: Single mode: tx request while tx empty.
// R13: Multi mode: rx request trigger-set, empty-cleared.
// R14: Multi mode: tx request while not full.
// R15: FIFO control bit 3 selects multi-transfer.
// R16: Core requests follow tx shadow empty and rx shadow present, not the status bits.
// R17: Core requests use undelayed shadow bits.
// R18: Line control bit 7 selects divisor access.
// R19: Tx empty sets on drain, clears on write.
// R20: Data present while receive data waits.
// R21: Core reads have no side effects.
`ifndef HUDE_CONSTS_VH
`define HUDE_CONSTS_VH
`define HUDE_OFS_DATA 3'h0
`define HUDE_OFS_IER 3'h1
`define HUDE_OFS_FCR 3'h2
`define HUDE_OFS_LCR 3'h3
`define HUDE_OFS_LSR 3'h5
`define HUDE_OFS_STORE 3'h7
`define HUDE_CORE_STORE 8'hF7
`define HUDE_CORE_DIV_LO 8'hF8
`define HUDE_CORE_DIV_HI 8'hF9
`define HUDE_CORE_RXDATA 8'hF0
`define HUDE_CORE_LSR 8'hF5
`define HUDE_LCR_DIV_BIT 7
`define HUDE_FCR_MULTI_BIT 3
`define HUDE_MCR_SWAP_BIT 3
`define HUDE_MCR_RXDMA_BIT 4
`define HUDE_MCR_TXDMA_BIT 5
`define HUDE_LSR_DR_BIT 0
`define HUDE_LSR_TX_HOLDING_EMPTY_BIT 5
`define HUDE_RESET_BYTE 8'h00
`endif

// [core/hude_fifo.v]
`timescale 1ns/1ps
`default_nettype none
module hude_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH_LOG2 = 4
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [DEPTH_LOG2:0] level_out
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wr_ptr;
  reg [DEPTH_LOG2:0] rd_ptr;
  wire push;
  wire pop;
  assign level_out = wr_ptr - rd_ptr;
  // The level reaches its top bit only when all entries are in use.
  assign in_ready_out = !level_out[DEPTH_LOG2];
  assign out_valid_out = (wr_ptr != rd_ptr);
  assign out_data_out = mem[rd_ptr[DEPTH_LOG2-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always @(posedge core_clk_in)
  begin
    if (push)
      mem[wr_ptr[DEPTH_LOG2-1:0]] <= in_data_in;
  end
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr <= {(DEPTH_LOG2+1){1'b0}};
      rd_ptr <= {(DEPTH_LOG2+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [core/hude_dma_req.v]
`timescale 1ns/1ps
`default_nettype none
`include "hude_consts.vh"
module hude_dma_req (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [7:0] master_ctrl_in,
  input wire multi_mode_in,
  input wire tx_holding_empty_in,
  input wire tx_shadow_empty_in,
  input wire tx_not_full_in,
  input wire rx_data_present_in,
  input wire rx_shadow_present_in,
  input wire rx_at_trigger_in,
  input wire core_dma_request0_n_in,
  input wire core_dma_request1_n_in,
  output wire host_tx_dma_ready_n_out,
  output wire host_rx_dma_ready_n_out,
  output wire core_dma_request0_n_out,
  output wire core_dma_request1_n_out
);
  reg rx_multi_req;
  wire tx_en;
  wire rx_en;
  wire swap;
  wire tx_req;
  wire rx_req;
  assign tx_en = master_ctrl_in[`HUDE_MCR_TXDMA_BIT]; // see R6
  assign rx_en = master_ctrl_in[`HUDE_MCR_RXDMA_BIT]; // see R6
  assign swap = master_ctrl_in[`HUDE_MCR_SWAP_BIT]; // see R6
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rx_multi_req <= 1'b0;
    else if (!rx_shadow_present_in)
      rx_multi_req <= 1'b0; // see R13
    else if (rx_at_trigger_in)
      rx_multi_req <= 1'b1; // see R13
  end
  // Single mode follows plain status, multi mode the FIFO thresholds.
  // The multi rx request drops in the very cycle the receive FIFO empties.
  assign tx_req = multi_mode_in ? tx_not_full_in :
    tx_holding_empty_in; // see R12 R14 R15
  assign rx_req = multi_mode_in ?
    ((rx_multi_req || rx_at_trigger_in) && rx_shadow_present_in) :
    rx_data_present_in; // see R11 R13 R15
  assign host_tx_dma_ready_n_out = tx_en ? ~tx_req : 1'b1; // see R7
  assign host_rx_dma_ready_n_out = rx_en ? ~rx_req : 1'b1; // see R9
  // Core requests use the undelayed shadow bits and override the pins.
  assign core_dma_request0_n_out =
    (tx_en && swap) ? ~tx_shadow_empty_in : // see R8 R16 R17
    (rx_en && !swap) ? ~rx_shadow_present_in : // see R10 R16 R17
    core_dma_request0_n_in;
  assign core_dma_request1_n_out =
    (tx_en && !swap) ? ~tx_shadow_empty_in : // see R8
    (rx_en && swap) ? ~rx_shadow_present_in : // see R10
    core_dma_request1_n_in;
endmodule
`default_nettype wire

// [core/hude_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "hude_consts.vh"
module hude_top #(
  parameter RX_TRIGGER = 5'h08
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [2:0] host_addr_in,
  input wire host_wr_in,
  input wire host_rd_in,
  input wire [7:0] host_wdata_in,
  output reg [7:0] host_rdata_out,
  input wire [7:0] core_addr_in,
  input wire core_rd_in,
  input wire core_wr_in,
  input wire [7:0] core_wdata_in,
  output reg [7:0] core_rdata_out,
  output reg core_divisor_irq_out,
  input wire core_irq_ack_in,
  input wire [7:0] master_ctrl_in,
  input wire tx_delay_done_in,
  input wire rx_delay_done_in,
  output wire core_tx_valid_out,
  input wire core_tx_ready_in,
  output wire [7:0] core_tx_data_out,
  input wire core_dma_request0_n_in,
  input wire core_dma_request1_n_in,
  output wire host_tx_dma_ready_n_out,
  output wire host_rx_dma_ready_n_out,
  output wire core_dma_request0_n_out,
  output wire core_dma_request1_n_out
);
  reg [7:0] host_storage_byte;
  reg [7:0] baud_divisor_low;
  reg [7:0] baud_divisor_high;
  reg [7:0] line_ctrl;
  reg [7:0] fifo_control_reg;
  reg [7:0] int_enable;
  reg tx_holding_empty;
  reg rx_data_present;
  reg [1:0] req0_sync;
  reg [1:0] req1_sync;
  wire div_sel;
  wire host_data_wr;
  wire host_data_rd;
  wire div_wr;
  wire tx_in_ready;
  wire rx_valid;
  wire [7:0] rx_data;
  wire [4:0] rx_level;
  wire rx_push;
  wire rx_pop;
  wire tx_shadow_empty;
  wire rx_shadow_present;
  assign div_sel = line_ctrl[`HUDE_LCR_DIV_BIT]; // see R18
  assign host_data_wr = host_wr_in && !div_sel &&
    host_addr_in == `HUDE_OFS_DATA; // see R18
  assign host_data_rd = host_rd_in && !div_sel &&
    host_addr_in == `HUDE_OFS_DATA; // see R18
  assign div_wr = host_wr_in && div_sel &&
    (host_addr_in == `HUDE_OFS_DATA || host_addr_in == `HUDE_OFS_IER);
  assign rx_push = core_wr_in && core_addr_in == `HUDE_CORE_RXDATA;
  assign rx_pop = host_data_rd && rx_valid;
  // Transmit path: host writes fill the FIFO, the core drains it.
  hude_fifo #(
    .WIDTH(8),
    .DEPTH_LOG2(4)
  ) tx_fifo (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(host_data_wr),
    .in_ready_out(tx_in_ready),
    .in_data_in(host_wdata_in),
    .out_valid_out(core_tx_valid_out),
    .out_ready_in(core_tx_ready_in),
    .out_data_out(core_tx_data_out),
    .level_out()
  );
  // Receive path: the core fills the FIFO, the host reads it out.
  hude_fifo #(
    .WIDTH(8),
    .DEPTH_LOG2(4)
  ) rx_fifo (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(rx_push),
    .in_ready_out(),
    .in_data_in(core_wdata_in),
    .out_valid_out(rx_valid),
    .out_ready_in(host_data_rd),
    .out_data_out(rx_data),
    .level_out(rx_level)
  );
  assign tx_shadow_empty = !core_tx_valid_out; // see R19
  assign rx_shadow_present = rx_valid; // see R20
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      host_storage_byte <= `HUDE_RESET_BYTE;
      baud_divisor_low <= `HUDE_RESET_BYTE;
      baud_divisor_high <= `HUDE_RESET_BYTE;
      line_ctrl <= `HUDE_RESET_BYTE;
      fifo_control_reg <= `HUDE_RESET_BYTE; // see R15
      int_enable <= `HUDE_RESET_BYTE;
    end
    else if (host_wr_in)
    begin
      case (host_addr_in)
        `HUDE_OFS_STORE:
          host_storage_byte <= host_wdata_in; // see R1 R2
        `HUDE_OFS_DATA:
          if (div_sel)
            baud_divisor_low <= host_wdata_in; // see R3
        `HUDE_OFS_IER:
          if (div_sel)
            baud_divisor_high <= host_wdata_in; // see R4
          else
            int_enable <= {4'h0, host_wdata_in[3:0]};
        `HUDE_OFS_FCR:
          fifo_control_reg <= host_wdata_in;
        `HUDE_OFS_LCR:
          line_ctrl <= host_wdata_in;
        default:
          line_ctrl <= line_ctrl;
      endcase
    end
  end
  // A divisor write sets the core interrupt; it beats a same-cycle ack.
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      core_divisor_irq_out <= 1'b0;
    else if (div_wr)
      core_divisor_irq_out <= 1'b1; // see R5
    else if (core_irq_ack_in)
      core_divisor_irq_out <= 1'b0;
  end
  // Host-visible status bits set after the shadows only once the optional delay timers are done; they clear without delay.
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_holding_empty <= 1'b1;
      rx_data_present <= 1'b0;
    end
    else
    begin
      if (host_data_wr)
        tx_holding_empty <= 1'b0; // see R19
      else if (tx_shadow_empty && tx_delay_done_in)
        tx_holding_empty <= 1'b1; // see R19
      if (!rx_valid || (rx_pop && !rx_push && rx_level == 5'h01))
        rx_data_present <= 1'b0; // see R20
      else if (rx_delay_done_in)
        rx_data_present <= 1'b1; // see R20
    end
  end
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req0_sync <= 2'b11;
      req1_sync <= 2'b11;
    end
    else
    begin
      req0_sync <= {req0_sync[0], core_dma_request0_n_in};
      req1_sync <= {req1_sync[0], core_dma_request1_n_in};
    end
  end
  hude_dma_req dma (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .master_ctrl_in(master_ctrl_in),
    .multi_mode_in(fifo_control_reg[`HUDE_FCR_MULTI_BIT]),
    .tx_holding_empty_in(tx_holding_empty),
    .tx_shadow_empty_in(tx_shadow_empty),
    .tx_not_full_in(tx_in_ready),
    .rx_data_present_in(rx_data_present),
    .rx_shadow_present_in(rx_shadow_present),
    .rx_at_trigger_in(rx_level >= RX_TRIGGER),
    .core_dma_request0_n_in(req0_sync[1]),
    .core_dma_request1_n_in(req1_sync[1]),
    .host_tx_dma_ready_n_out(host_tx_dma_ready_n_out),
    .host_rx_dma_ready_n_out(host_rx_dma_ready_n_out),
    .core_dma_request0_n_out(core_dma_request0_n_out),
    .core_dma_request1_n_out(core_dma_request1_n_out)
  );
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      host_rdata_out <= `HUDE_RESET_BYTE;
    else if (host_rd_in)
    begin
      case (host_addr_in)
        `HUDE_OFS_DATA:
          host_rdata_out <= div_sel ? baud_divisor_low : rx_data;
        `HUDE_OFS_IER:
          host_rdata_out <= div_sel ? baud_divisor_high : int_enable;
        `HUDE_OFS_LCR:
          host_rdata_out <= line_ctrl;
        `HUDE_OFS_LSR:
          host_rdata_out <= {2'b00, tx_holding_empty, 4'h0, rx_data_present};
        `HUDE_OFS_STORE:
          host_rdata_out <= host_storage_byte; // see R1
        default:
          host_rdata_out <= 8'h00;
      endcase
    end
  end
  // Core reads only copy state out; nothing is cleared by them.
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      core_rdata_out <= `HUDE_RESET_BYTE;
    else if (core_rd_in)
    begin
      case (core_addr_in)
        `HUDE_CORE_STORE:
          core_rdata_out <= host_storage_byte; // see R1 R21
        `HUDE_CORE_DIV_LO:
          core_rdata_out <= baud_divisor_low; // see R3 R21
        `HUDE_CORE_DIV_HI:
          core_rdata_out <= baud_divisor_high; // see R4 R21
        `HUDE_CORE_LSR:
          core_rdata_out <= {2'b00, tx_shadow_empty, 4'h0, rx_shadow_present};
        default:
          core_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// [bench/hude_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module hude_asserts #(parameter RX_TRIGGER = 5'h08) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic [7:0] core_addr_in,
  input wire logic core_wr_in,
  input wire logic core_divisor_irq_out,
  input wire logic core_irq_ack_in,
  input wire logic [7:0] master_ctrl_in,
  input wire logic core_tx_valid_out,
  input wire logic core_tx_ready_in,
  input wire logic tx_delay_done_in,
  input wire logic rx_delay_done_in,
  input wire logic host_tx_dma_ready_n_out,
  input wire logic host_rx_dma_ready_n_out,
  input wire logic core_dma_request0_n_out,
  input wire logic core_dma_request1_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic dsel, multi;
  logic [4:0] rxc, txc;
  wire logic [7:0] m = master_ctrl_in;
  wire logic at0 = !dsel && host_addr_in == 3'h0;
  wire logic rxp = core_wr_in && core_addr_in == 8'hF0 && rxc != 5'h10;
  wire logic rxq = host_rd_in && at0 && rxc != 5'h00;
  wire logic txp = host_wr_in && at0 && txc != 5'h10;
  wire logic txq = core_tx_valid_out && core_tx_ready_in;
  wire logic tsel = m[3] ? core_dma_request0_n_out : core_dma_request1_n_out;
  wire logic rsel = m[3] ? core_dma_request1_n_out : core_dma_request0_n_out;
  // Mirrors of divisor select, transfer mode and both FIFO fill levels.
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      {dsel, multi, rxc, txc} <= 12'h000;
    else
    begin
      if (host_wr_in && host_addr_in == 3'h3)
        dsel <= host_wdata_in[7];
      if (host_wr_in && host_addr_in == 3'h2)
        multi <= host_wdata_in[3];
      rxc <= rxc + {4'h0, rxp} - {4'h0, rxq};
      txc <= txc + {4'h0, txp} - {4'h0, txq};
    end
  AST_STORE_NO_IRQ: assert property (
    host_wr_in && host_addr_in == 3'h7 && !core_divisor_irq_out
    |=> !core_divisor_irq_out) else $error("storage write raised irq");
  AST_DIV_IRQ: assert property (
    host_wr_in && dsel && host_addr_in <= 3'h1 |=> core_divisor_irq_out)
    else $error("divisor write gave no irq");
  AST_IRQ_STANDS: assert property (
    core_divisor_irq_out && !core_irq_ack_in |=> core_divisor_irq_out)
    else $error("irq dropped without ack");
  AST_TX_SINGLE: assert property (
    m[5] && !multi && (core_tx_valid_out || $past(core_tx_valid_out))
    |-> host_tx_dma_ready_n_out) else $error("single mode tx ready wrong");
  AST_TX_SINGLE_SET: assert property (
    m[5] && !multi && !core_tx_valid_out && !$past(core_tx_valid_out) &&
    $past(tx_delay_done_in) |-> !host_tx_dma_ready_n_out)
    else $error("single mode tx ready missing");
  AST_TX_MULTI: assert property (
    m[5] && multi |-> host_tx_dma_ready_n_out == (txc == 5'h10))
    else $error("multi mode tx ready wrong");
  AST_CORE_TX: assert property (
    m[5] |-> tsel == core_tx_valid_out) else $error("core tx request wrong");
  AST_CORE_RX: assert property (
    m[4] |-> rsel == (rxc == 5'h00)) else $error("core rx request wrong");
  AST_RX_SINGLE: assert property (
    m[4] && !multi && rxc == 5'h00 |-> host_rx_dma_ready_n_out)
    else $error("single mode rx ready wrong");
  AST_RX_SINGLE_SET: assert property (
    m[4] && !multi && rxc != 5'h00 && $past(rxc) != 5'h00 &&
    $past(rx_delay_done_in) |-> !host_rx_dma_ready_n_out)
    else $error("single mode rx ready missing");
  AST_RX_MULTI: assert property (
    m[4] && multi |-> (rxc < RX_TRIGGER || !host_rx_dma_ready_n_out)
    && (rxc != 5'h00 || host_rx_dma_ready_n_out))
    else $error("multi mode rx ready wrong");
endmodule
bind hude_top hude_asserts #(.RX_TRIGGER(RX_TRIGGER)) i_chk (.*);
`default_nettype wire

// [bench/hude_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hude_host_model (
  input wire logic clk_in,
  input wire logic tx_rdy_n_in,
  input wire logic rx_rdy_n_in,
  input wire logic [7:0] rdata_in,
  output var logic [2:0] addr_out = 3'h0,
  output var logic wr_out = 1'b0,
  output var logic rd_out = 1'b0,
  output var logic [7:0] wdata_out = 8'h00
);
  // Released write data shows its inverse so a stale byte is never trusted.
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  task automatic get(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask
  // Host DMA: moves a byte only while its ready pin is low, stalling at will.
  task automatic dma(input int n, input logic [31:0] st);
    logic [7:0] d;
    for (int i = 0; i < n; i++)
      if (st[i % 32])
        @(posedge clk_in);
      else if (!tx_rdy_n_in)
        put(3'h0, 8'(i) ^ st[15:8]);
      else if (!rx_rdy_n_in)
        get(3'h0, d);
      else
        @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// [bench/hude_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module host_uart_emulation_dma_tb_top;
  localparam logic [4:0] TRIG = 5'h08;
  int miscompares = 0, n_tests = 0, seed = 71385, i;
  logic [7:0] v, got, exp_q [16];
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, core_rd_in = 1'b0;
  logic core_wr_in = 1'b0, core_irq_ack_in = 1'b0, core_tx_ready_in = 1'b0;
  logic core_dma_request0_n_in = 1'b1, core_dma_request1_n_in = 1'b1;
  logic [7:0] core_addr_in = 8'h00, core_wdata_in = 8'h00;
  logic [7:0] master_ctrl_in = 8'h00;
  logic tx_delay_done_in = 1'b1, rx_delay_done_in = 1'b1;
  wire logic [2:0] host_addr_in;
  wire logic [7:0] host_wdata_in, host_rdata_out, core_rdata_out;
  wire logic [7:0] core_tx_data_out;
  wire logic host_wr_in, host_rd_in, core_divisor_irq_out, core_tx_valid_out;
  wire logic host_tx_dma_ready_n_out, host_rx_dma_ready_n_out;
  wire logic core_dma_request0_n_out, core_dma_request1_n_out;
  hude_top #(.RX_TRIGGER(TRIG)) i_dut (.*);
  hude_host_model i_host (.clk_in(core_clk_in),
    .tx_rdy_n_in(host_tx_dma_ready_n_out),
    .rx_rdy_n_in(host_rx_dma_ready_n_out),
    .rdata_in(host_rdata_out), .addr_out(host_addr_in), .wr_out(host_wr_in),
    .rd_out(host_rd_in), .wdata_out(host_wdata_in));
  initial
    forever #20 core_clk_in = ~core_clk_in;
  function automatic logic rx_ready_n(input int cnt);
    return cnt < TRIG;
  endfunction
  task automatic core_acc(input logic w, input logic [7:0] a, d);
    @(posedge core_clk_in);
    core_addr_in <= a;
    core_wdata_in <= d;
    core_wr_in <= w;
    core_rd_in <= !w;
    @(posedge core_clk_in);
    core_wr_in <= 1'b0;
    core_rd_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic summarize();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    v = $random(seed);
    i_host.put(3'h7, v);
    i_host.get(3'h7, got);
    `CHK("store host", v, got)
    core_acc(1'b0, 8'hF7, 8'h00);
    `CHK("store core", v, core_rdata_out)
    `CHK("store irq", 1'b0, core_divisor_irq_out)
    i_host.put(3'h3, 8'h80);
    for (i = 0; i < 2; i++)
    begin
      v = $random(seed);
      i_host.put(i[2:0], v);
      #1 `CHK("div irq", 1'b1, core_divisor_irq_out)
      @(posedge core_clk_in);
      core_irq_ack_in <= 1'b1;
      @(posedge core_clk_in);
      core_irq_ack_in <= 1'b0;
      repeat (2) core_acc(1'b0, 8'hF8 + 8'(i), 8'h00);
      `CHK("div core", v, core_rdata_out)
      `CHK("irq ack", 1'b0, core_divisor_irq_out)
      i_host.get(i[2:0], got);
      `CHK("div host", v, got)
    end
    i_host.put(3'h3, 8'h00);
    i_host.put(3'h2, 8'h08);
    master_ctrl_in <= 8'h20;
    for (i = 0; i < 17; i++)
    begin
      v = $random(seed);
      if (i < 16)
        exp_q[i] = v;
      i_host.put(3'h0, v);
    end
    #1 `CHK("tx full", 1'b1, host_tx_dma_ready_n_out)
    `CHK("tx req", 1'b1, core_dma_request1_n_out)
    for (i = 0; i < 16; i++)
    begin
      @(posedge core_clk_in);
      `CHK("tx data", exp_q[i], core_tx_data_out)
      core_tx_ready_in <= 1'b1;
      @(posedge core_clk_in);
      core_tx_ready_in <= 1'b0;
    end
    #1 `CHK("tx empty", 1'b0, core_tx_valid_out)
    `CHK("tx req", 1'b0, core_dma_request1_n_out)
    i_host.get(3'h5, got);
    `CHK("host status", 8'h20, got)
    core_acc(1'b0, 8'hF5, 8'h00);
    `CHK("core status", 8'h20, core_rdata_out)
    master_ctrl_in <= 8'h18;
    for (i = 1; i <= 8; i++)
    begin
      core_acc(1'b1, 8'hF0, 8'(i));
      `CHK("rx multi", rx_ready_n(i), host_rx_dma_ready_n_out)
    end
    i_host.get(3'h5, got);
    `CHK("rx status", 8'h21, got)
    i_host.get(3'h0, got);
    `CHK("rx data", 8'h01, got)
    `CHK("rx hold", 1'b0, host_rx_dma_ready_n_out)
    `CHK("rx req", 1'b0, core_dma_request1_n_out)
    i_host.dma(60, $random(seed));
    `CHK("rx drained", 1'b1, host_rx_dma_ready_n_out)
    master_ctrl_in <= 8'h00;
    core_dma_request0_n_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    `CHK("pass req", 1'b0, core_dma_request0_n_out)
    `CHK("idle tx", 1'b1, host_tx_dma_ready_n_out)
    for (i = 0; i < 16; i++)
    begin
      i_host.put(3'h2, {4'h0, i[3], 3'h0});
      master_ctrl_in <= {2'h0, i[2:0], 3'h0};
      repeat (3) core_acc(1'b1, 8'hF0, 8'($random(seed)));
      fork
        i_host.dma(40, $random(seed));
        repeat (40)
        begin
          @(posedge core_clk_in);
          core_tx_ready_in <= 1'($random(seed));
          {core_dma_request0_n_in, core_dma_request1_n_in} <=
            2'($random(seed));
          {tx_delay_done_in, rx_delay_done_in} <= 2'($random(seed));
        end
      join
    end
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
